// *** rtl/lamp_params.svh ***
// timing constants and encodings for the status lamp driver
`ifndef LAMP_PARAMS_SVH
`define LAMP_PARAMS_SVH
// Overview of operation
// [R1] Blinking holds the lamp on for 200 ms, then off for 200 ms, repeating.
// [R2] Flickering holds the lamp on for 50 ms, then off for 50 ms, repeating.
// [R3] Single flash is on for 200 ms, then off for 1000 ms, repeating.
// [R4] Double flash is on 200, off 200, on 200, off 1000 ms, repeating.
// [R5] The state lamp is off, flickers, blinks, single-flashes or is steady on, following the slave state.
// [R6] The fault lamp is off, blinks, single-flashes or double-flashes, following the error cause.
// [R7] Each port lamp is off with no link and blinks while linked and receiving.
// [R8] The four user lamps follow software control bits directly.
// [R9] All timing comes from one millisecond tick, and a new pattern restarts with its on phase.

// -------------------------------------------------------------------
// timing
// -------------------------------------------------------------------
`define CLK_FREQ_HZ      100000000
`define TICK_PERIOD_MS   1
`define TICK_CYCLES      ((`CLK_FREQ_HZ / 1000) * `TICK_PERIOD_MS)
`define BLINK_ON_MS      200
`define BLINK_OFF_MS     200
`define FLICKER_ON_MS    50
`define FLICKER_OFF_MS   50
`define FLASH_ON_MS      200
`define FLASH_GAP_MS     200
`define FLASH_OFF_MS     1000
// -------------------------------------------------------------------
// slave state encoding on slave_state_i
// -------------------------------------------------------------------
`define ST_INIT          3'h1
`define ST_BOOT          3'h3
`define ST_PREOP         3'h2
`define ST_SAFEOP        3'h4
`define ST_OP            3'h0
`endif

// *** rtl/lamp_pkg.sv ***
// types shared by the status lamp driver
package lamp_pkg;
    typedef enum logic [2:0] {
        PAT_OFF,
        PAT_ON,
        PAT_BLINK,
        PAT_FLICKER,
        PAT_SINGLE,
        PAT_DOUBLE
    } pattern_type;

    // error causes, highest priority first: watchdog, config, failed change
    typedef struct packed {
        logic watchdog_expired;
        logic config_error;
        logic change_failed;
    } fault_type;

    typedef struct packed {
        logic link_up;
        logic rx_active;
    } port_type;
endpackage

// *** rtl/slave_status_led_driver.sv ***
// status lamp pattern generator for the slave controller board
`include "lamp_params.svh"
`timescale 1ns/1ps
`default_nettype none

// -------------------------------------------------------------------
// one lamp sequencer: runs a pattern from the shared millisecond tick
// -------------------------------------------------------------------
module lamp_sequencer
    import lamp_pkg::*;
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    // timing and selection
    input  wire logic        tick_i,
    input  var  pattern_type pattern_i,
    // lamp
    output logic             lamp_o
);
    logic [9:0]  ms_reg;
    logic [9:0]  ms_next;
    logic [1:0]  phase_reg;
    logic [1:0]  phase_next;
    pattern_type last_reg;
    logic        lamp_reg;
    logic        lamp_next;
    logic [9:0]  phase_len;
    logic        restart;
    logic        phase_done;
    logic [1:0]  last_phase;
    logic [9:0]  blink_len;
    logic [9:0]  flicker_len;

    // blink and flicker keep separate on and off lengths, so either
    // can be retuned without disturbing the other
    assign blink_len   = phase_reg[0] ? 10'(`BLINK_OFF_MS)
                                      : 10'(`BLINK_ON_MS);         // R1
    assign flicker_len = phase_reg[0] ? 10'(`FLICKER_OFF_MS)
                                      : 10'(`FLICKER_ON_MS);       // R2

    // phase lengths; phase 0 is always the on phase
    assign phase_len =
        (pattern_i == PAT_FLICKER)                 ? flicker_len :         // R2
        (pattern_i == PAT_BLINK)                   ? blink_len :           // R1
        (phase_reg == 2'h0 || phase_reg == 2'h2)   ? 10'(`FLASH_ON_MS) :
        (pattern_i == PAT_DOUBLE && phase_reg == 2'h1) ?
                                                     10'(`FLASH_GAP_MS) :  // R4
                                                     10'(`FLASH_OFF_MS);   // R3
    // single flash has two phases, double flash four
    assign last_phase = (pattern_i == PAT_DOUBLE) ? 2'h3 : 2'h1;
    assign restart    = (pattern_i != last_reg);                           // R9
    assign phase_done = tick_i && (ms_reg == phase_len - 10'h001);

    // next-state of the phase counters
    always_comb begin
        ms_next    = ms_reg;
        phase_next = phase_reg;
        if (restart) begin
            ms_next    = 10'h000;
            phase_next = 2'h0;                                             // R9
        end else if (phase_done) begin
            ms_next    = 10'h000;
            phase_next = (phase_reg == last_phase) ? 2'h0 : phase_reg + 2'h1;
        end else if (tick_i) begin
            ms_next = ms_reg + 10'h001;
        end
    end

    // even phases light the lamp; steady patterns ignore the phase
    always_comb begin
        case (pattern_i)
            PAT_OFF: lamp_next = 1'b0;
            PAT_ON:  lamp_next = 1'b1;
            default: lamp_next = ~phase_next[0];                       // R1 R2 R3 R4
        endcase
    end

    // registers; lamp output is a flip-flop to avoid decode glitches
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            ms_reg    <= 10'h000;
            phase_reg <= 2'h0;
            last_reg  <= PAT_OFF;
            lamp_reg  <= 1'b0;
        end else begin
            ms_reg    <= ms_next;
            phase_reg <= phase_next;
            last_reg  <= pattern_i;
            lamp_reg  <= lamp_next;
        end
    end

    assign lamp_o = lamp_reg;
endmodule

// -------------------------------------------------------------------
// top: tick divider, input synchronisers, pattern selection
// -------------------------------------------------------------------
module slave_status_led_driver
    import lamp_pkg::*;
#(
    parameter int PORTS       = 2,
    parameter int TICK_CYCLES = `TICK_CYCLES
)
(
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             sys_rst_i,
    // slave controller status, same clock domain
    input  wire logic [2:0]       slave_state_i,
    input  var  fault_type        fault_i,
    // per-port link status from the phys, asynchronous
    input  var  port_type [PORTS-1:0] port_i,
    // software control bits
    input  wire logic [3:0]       user_bits_i,
    // lamp drives
    output logic                  state_lamp_drive_o,
    output logic                  fault_lamp_drive_o,
    output logic [PORTS-1:0]      port_lamp_o,
    output logic                  user_lamp_one_o,
    output logic                  user_lamp_two_o,
    output logic                  user_lamp_three_o,
    output logic                  user_lamp_four_o
);
    // refuse settings the divider or the port loop cannot serve;
    // checked while elaborating, so a bad build never starts
    if (TICK_CYCLES < 2 || PORTS < 1) begin : g_bad_params
        $error("slave_status_led_driver: bad parameters");
    end

    logic [31:0]       div_reg;
    logic              tick_reg;
    logic [3:0]        user_reg;
    port_type [PORTS-1:0] port_meta_reg;
    port_type [PORTS-1:0] port_sync_reg;
    pattern_type       state_pat;
    pattern_type       fault_pat;
    wire               tick_wrap = (div_reg == 32'(TICK_CYCLES - 1));

    // free-running millisecond tick shared by the state, fault and port lamps
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            div_reg  <= 32'h0;
            tick_reg <= 1'b0;
        end else begin
            div_reg  <= tick_wrap ? 32'h0 : div_reg + 32'h1;           // R9
            tick_reg <= tick_wrap;
        end
    end

    // phy status is asynchronous: two flops before use
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            port_meta_reg <= '0;
            port_sync_reg <= '0;
        end else begin
            port_meta_reg <= port_i;
            port_sync_reg <= port_meta_reg;
        end
    end

    // slave state to pattern
    assign state_pat =
        (slave_state_i == `ST_BOOT)   ? PAT_FLICKER :
        (slave_state_i == `ST_PREOP)  ? PAT_BLINK :
        (slave_state_i == `ST_SAFEOP) ? PAT_SINGLE :
        (slave_state_i == `ST_OP)     ? PAT_ON : PAT_OFF;               // R5

    // error cause to pattern; watchdog outranks the others
    assign fault_pat =
        fault_i.watchdog_expired ? PAT_DOUBLE :
        fault_i.config_error     ? PAT_SINGLE :
        fault_i.change_failed    ? PAT_BLINK : PAT_OFF;                 // R6

    lamp_sequencer u_state (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .tick_i    (tick_reg),
        .pattern_i (state_pat),
        .lamp_o    (state_lamp_drive_o)
    );

    lamp_sequencer u_fault (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .tick_i    (tick_reg),
        .pattern_i (fault_pat),
        .lamp_o    (fault_lamp_drive_o)
    );

    // one link/activity lamp per port
    generate
        for (genvar p = 0; p < PORTS; p++) begin : g_port
            pattern_type port_pat;
            // blinks only when linked and receiving
            assign port_pat = (port_sync_reg[p].link_up &&
                               port_sync_reg[p].rx_active) ?
                              PAT_BLINK : PAT_OFF;                      // R7
            lamp_sequencer u_port (
                .clk_i     (clk_i),
                .sys_rst_i (sys_rst_i),
                .tick_i    (tick_reg),
                .pattern_i (port_pat),
                .lamp_o    (port_lamp_o[p])
            );
        end
    endgenerate

    // user lamps: registered copy of the software bits
    always_ff @(posedge clk_i) begin
        if (sys_rst_i)
            user_reg <= 4'h0;
        else
            user_reg <= user_bits_i;                                    // R8
    end

    assign user_lamp_one_o   = user_reg[0];
    assign user_lamp_two_o   = user_reg[1];
    assign user_lamp_three_o = user_reg[2];
    assign user_lamp_four_o  = user_reg[3];
endmodule

`default_nettype wire

// *** dv/lamp_checker_sva.sv ***
// bound assertion checker for the status lamp driver
`include "lamp_params.svh"
`timescale 1ns/1ps
`default_nettype none
module lamp_checker
    import lamp_pkg::*;
#(
    parameter int PORTS       = 2,
    parameter int TICK_CYCLES = `TICK_CYCLES
)
(
    // clock, reset and inputs
    input wire logic                 clk_i,
    input wire logic                 sys_rst_i,
    input wire logic [2:0]           slave_state_i,
    input var  fault_type            fault_i,
    input var  port_type [PORTS-1:0] port_i,
    input wire logic [3:0]           user_bits_i,
    // lamp drives
    input wire logic                 state_lamp_drive_o,
    input wire logic                 fault_lamp_drive_o,
    input wire logic [PORTS-1:0]     port_lamp_o,
    input wire logic                 user_lamp_one_o,
    input wire logic                 user_lamp_two_o,
    input wire logic                 user_lamp_three_o,
    input wire logic                 user_lamp_four_o
);
    localparam int TK = TICK_CYCLES;
    int         s_run;
    int         s_age;
    int         f_age;
    logic       s_prv;
    logic [2:0] s_st;
    fault_type  f_prv;

    // phase lengths and input ages; phase one may be a tick off, so skip it
    always_ff @(posedge clk_i) begin
        s_prv <= state_lamp_drive_o;
        s_st  <= slave_state_i;
        f_prv <= fault_i;
        s_run <= (state_lamp_drive_o != s_prv) ? 1 : s_run + 1;
        s_age <= (slave_state_i != s_st) ? 0 : s_age + 1;
        f_age <= (fault_i != f_prv) ? 0 : f_age + 1;
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    property p_init_off;
        (slave_state_i == `ST_INIT) [*3] |-> !state_lamp_drive_o;
    endproperty
    a_init_off: assert property (p_init_off) else $error("lit in init");
    property p_op_on;
        (slave_state_i == `ST_OP) [*3] |-> state_lamp_drive_o;
    endproperty
    a_op_on: assert property (p_op_on) else $error("dark in op");
    property p_restart;
        $changed(slave_state_i) && slave_state_i != `ST_INIT
            && slave_state_i < 3'h5 ##1 $stable(slave_state_i)
            |-> ##1 state_lamp_drive_o;
    endproperty
    a_restart: assert property (p_restart) else $error("no on start");
    property p_blink;
        slave_state_i == `ST_PREOP && s_age > 250 * TK
            && $changed(state_lamp_drive_o) |-> s_run == 200 * TK;
    endproperty
    a_blink: assert property (p_blink) else $error("blink length");
    property p_single;
        slave_state_i == `ST_SAFEOP && s_age > 300 * TK
            && $changed(state_lamp_drive_o)
            |-> s_run == (state_lamp_drive_o ? 1000 : 200) * TK;
    endproperty
    a_single: assert property (p_single) else $error("flash length");
    property p_wd_off;
        fault_i.watchdog_expired && f_age == 900 * TK |-> !fault_lamp_drive_o;
    endproperty
    a_wd_off: assert property (p_wd_off) else $error("not double");
    // the second flash sits where single flash is dark but blink is lit
    property p_wd_on;
        fault_i.watchdog_expired && f_age == 500 * TK |-> fault_lamp_drive_o;
    endproperty
    a_wd_on: assert property (p_wd_on) else $error("no second flash");
    property p_port_off;
        (port_i[0] != 2'b11) [*6] |-> !port_lamp_o[0];
    endproperty
    a_port_off: assert property (p_port_off) else $error("port lit");
    property p_user;
        !$past(sys_rst_i) |-> {user_lamp_four_o, user_lamp_three_o,
            user_lamp_two_o, user_lamp_one_o} == $past(user_bits_i);
    endproperty
    a_user: assert property (p_user) else $error("user lamps");
endmodule

bind slave_status_led_driver lamp_checker
    #(.PORTS(PORTS), .TICK_CYCLES(TICK_CYCLES)) chk_u (.*);
`default_nettype wire

// *** dv/tb_slave_status_led_driver.sv ***
// self-checking bench for the status lamp driver
`include "lamp_params.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_slave_status_led_driver
    import lamp_pkg::*;
;
    localparam int  TK = 10;
    logic           clk_i = 0;
    logic           sys_rst_i = 1;
    logic           armed = 0;
    logic           prev = 0;
    logic [2:0]     slave_state_i = `ST_INIT;
    fault_type      fault_i = '0;
    port_type [1:0] port_i = '0;
    logic [3:0]     user_bits_i = '0;
    wire [3:0]      lamps;
    wire [3:0]      ulamps;
    logic [3:0]     ub;
    logic [3:0]     u;
    logic [3:0]     uq[$];
    int             sel = 0, age = 0, e, d, err_count = 0, n_compared = 0;
    int             q[$];

    // short tick keeps the long phases affordable
    slave_status_led_driver #(.PORTS(2), .TICK_CYCLES(TK)) dut_u (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .slave_state_i(slave_state_i),
        .fault_i(fault_i), .port_i(port_i), .user_bits_i(user_bits_i),
        .state_lamp_drive_o(lamps[0]), .fault_lamp_drive_o(lamps[1]),
        .port_lamp_o(lamps[3:2]), .user_lamp_one_o(ulamps[0]),
        .user_lamp_two_o(ulamps[1]), .user_lamp_three_o(ulamps[2]),
        .user_lamp_four_o(ulamps[3]));

    // clock
    initial forever #5 clk_i = ~clk_i;

    // fresh software bits every cycle, each noted for its lamp check
    always @(posedge clk_i) begin
        if (sys_rst_i)
            uq.delete();
        ub = 4'($urandom);
        user_bits_i <= ub;
        uq.push_back(ub);
    end

    // user lamps settle after the edge that loads them: look between edges
    always @(negedge clk_i) begin
        if (uq.size() == 2) begin
            u = uq.pop_front();
            n_compared++;
            if (ulamps !== u) begin
                err_count++;
                $display("CHECK FAILED t=%0t got %h exp %h", $time,
                    ulamps, u);
            end
        end
    end

    // watcher: each edge of the selected lamp takes the oldest note
    always @(posedge clk_i) begin
        age <= (lamps[sel] !== prev) ? 1 : age + 1;
        prev <= lamps[sel];
        if (armed && lamps[sel] !== prev) begin
            e = (q.size() > 0) ? q.pop_front() : -1;
            d = (e >>> 1) * TK - age;
            n_compared++;
            if (e < 0 || lamps[sel] !== e[0]
                    || (e > 1 && (d > TK || d < -TK))) begin
                err_count++;
                $display("CHECK FAILED t=%0t got %h/%h exp %h/%h", $time,
                    lamps[sel], age, e[0], (e >>> 1) * TK);
            end
        end
    end

    // quiet the lamps, then select a pattern and note its edges in ms
    task automatic go(input logic [2:0] st, input fault_type f,
            input port_type [1:0] p, input int s, n, a, b);
        @(posedge clk_i);
        armed <= 0;
        slave_state_i <= `ST_INIT;
        fault_i <= '0;
        port_i <= '0;
        repeat (20) @(posedge clk_i);
        sel <= s;
        armed <= 1;
        for (int i = 0; i < n; i++)
            q.push_back(2 * (i == 0 ? 0 : i == 4 ? 1000 : i % 2 ? a : b)
                + (i % 2 == 0));
        @(posedge clk_i);
        slave_state_i <= st;
        fault_i <= f;
        port_i <= p;
        for (int i = 0; i < 20000 && q.size() > 0; i++) @(posedge clk_i);
        repeat (300) @(posedge clk_i);
        n_compared++;
        if (q.size() != 0) begin
            err_count++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, q.size(), 0);
        end
        q.delete();
    endtask

    task automatic results();
        if (err_count == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        void'($urandom(23323));
        repeat (8) @(posedge clk_i);
        sys_rst_i <= 0;
        go(`ST_INIT, 3'h0, 4'h0, 0, 0, 0, 0);
        go(`ST_OP, 3'h0, 4'h0, 0, 1, 0, 0);
        go(`ST_BOOT, 3'h0, 4'h0, 0, 4, 50, 50);
        go(`ST_PREOP, 3'h0, 4'h0, 0, 4, 200, 200);
        go(`ST_SAFEOP, 3'h0, 4'h0, 0, 3, 200, 1000);
        go(3'h7, 3'h0, 4'h0, 0, 0, 0, 0);
        go(`ST_INIT, 3'h1, 4'h0, 1, 3, 200, 200);
        go(`ST_INIT, 3'h3, 4'h0, 1, 3, 200, 1000);
        go(`ST_INIT, 3'h7, 4'h0, 1, 5, 200, 200);
        go(`ST_INIT, 3'h0, 4'hA, 2, 0, 0, 0);
        go(`ST_INIT, 3'h0, 4'h3, 2, 3, 200, 200);
        go(`ST_INIT, 3'h0, 4'hC, 3, 3, 200, 200);
        results();
    end

    // watchdog a little beyond the expected run length
    initial begin
        repeat (90000) @(posedge clk_i);
        err_count++;
        results();
    end
endmodule
`default_nettype wire
